// File: hdl/dtm_pkg.sv
// Purpose: Shared constants for the dual timer mode-control block.
// Assumes: One 8-bit special-function-register space, one system clock.
// Notes:   Field positions and reset values of the timer mode register live here.
package dtm_pkg;

	// Address of the timer mode register in the special-function-register space.
	localparam logic [7:0] TIMER_MODE_CONTROL_ADDR = 8'h89;
	// Value of the timer mode register after reset.
	localparam logic [7:0] TIMER_MODE_CONTROL_RST  = 8'h00;

	// Field positions inside the timer mode register.
	localparam int TIMER_ONE_GATE_SEL_POS    = 7;
	localparam int TIMER_ONE_COUNT_SEL_POS   = 6;
	localparam int TIMER_ONE_MODE_FIELD_LSB  = 4;
	localparam int TIMER_ZERO_GATE_SEL_POS   = 3;
	localparam int TIMER_ZERO_COUNT_SEL_POS  = 2;
	localparam int TIMER_ZERO_MODE_FIELD_LSB = 0;

	// Division ratio of the slow internal timebase.
	localparam int          PRESCALE_DIV      = 12;
	localparam logic [3:0]  PRESCALE_CNT_LAST = 4'(PRESCALE_DIV - 1);
	localparam logic [3:0]  PRESCALE_CNT_RST  = 4'h0;

	// Operating modes selected by a two-bit mode field.
	typedef enum logic [1:0] {
		MODE_13BIT  = 2'b00,
		MODE_16BIT  = 2'b01,
		MODE_8RELOAD = 2'b10,
		MODE_STOP   = 2'b11
	} dtm_mode_type;

endpackage : dtm_pkg

// File: hdl/dtm_top.sv
// What this block does
// - Timer one gate clear: run bit alone enables.
// - Timer one gate set: run and gate high.
// - Timer one timer mode counts internal clock.
// - Timer one counter mode counts pin falls.
// - Timer one modes 00 13-bit, 01 16-bit.
// - Timer one mode 10 is 8-bit reload.
// - Timer one mode 11 stops counting.
// - Timer zero gate clear: run bit alone enables.
// - Timer zero gate set: run and gate high.
// - Timer zero timer mode counts internal clock.
// - Timer zero counter mode counts pin falls.
// - Bits one to zero pick timer zero mode.
//
// Purpose: Timer mode register and its count-enable decode for two timers.
// Assumes: Counter datapaths elsewhere consume the increment pulses and mode decode.
// Notes:   Pins pass a two-flop synchroniser, so pin effects lag by three cycles.

// Per-timer decode of gate, source and mode into a registered increment pulse.
module dtm_timer_ctl #(
	parameter bit STOP_ON_MODE3 = 1'b1
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Configuration from the mode register, plus the run and prescale bits.
	input  wire logic       gate_sel,
	input  wire logic       count_sel,
	input  wire logic [1:0] mode,
	input  wire logic       prescale_sel,
	input  wire logic       run,
	// Board pins and the slow timebase.
	input  wire logic       gate_pin,
	input  wire logic       count_pin,
	input  wire logic       tick_slow,
	// Results.
	output logic            inc_q,
	output logic            enabled_q,
	output logic [3:0]      mode_dec_q
);

	logic gate_s1_q;   // First synchroniser stage of the gate pin.
	logic gate_s2_q;   // Second synchroniser stage of the gate pin.
	logic cnt_s1_q;    // First synchroniser stage of the count pin.
	logic cnt_s2_q;    // Second synchroniser stage of the count pin.
	logic cnt_s3_q;    // Delayed copy used for edge detection.
	logic fall;        // One-cycle falling edge of the count pin.
	logic enabled_d;   // Gate and run combination.
	logic tick_int;    // Internal timebase selected by the prescale bit.
	logic stopped;     // Mode field asks the timer to hold.
	logic inc_d;       // Next increment pulse.

	// The synchronisers keep metastability away from the decode logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_s1_q <= 1'b0;
			gate_s2_q <= 1'b0;
			cnt_s1_q  <= 1'b0;
			cnt_s2_q  <= 1'b0;
			cnt_s3_q  <= 1'b0;
		end else begin
			gate_s1_q <= gate_pin;
			gate_s2_q <= gate_s1_q;
			cnt_s1_q  <= count_pin;
			cnt_s2_q  <= cnt_s1_q;
			cnt_s3_q  <= cnt_s2_q;
		end
	end

	// Edge detection reads only settled stages, so one fall gives one pulse.
	assign fall      = cnt_s3_q & ~cnt_s2_q;
	// With the gate bit clear the pin level is ignored; set, it must be high.
	assign enabled_d = run & (~gate_sel | gate_s2_q);
	// Prescale bit set counts every system clock, clear counts the slow tick.
	assign tick_int  = prescale_sel | tick_slow;
	// Mode three holds the count where the instance is told to stop.
	assign stopped   = STOP_ON_MODE3 && (mode == dtm_pkg::MODE_STOP);

	// Counter function uses pin falls, timer function uses the internal clock.
	always_comb begin
		inc_d = 1'b0;
		if (enabled_d && !stopped) begin
			if (count_sel) begin
				inc_d = fall;
			end else begin
				inc_d = tick_int;
			end
		end
	end

	// Outputs are registered so downstream logic sees clean levels.
	always_ff @(posedge clk) begin
		if (rst) begin
			inc_q      <= 1'b0;
			enabled_q  <= 1'b0;
			mode_dec_q <= 4'h1;
		end else begin
			inc_q      <= inc_d;
			enabled_q  <= enabled_d;
			mode_dec_q <= 4'h1 << mode;
		end
	end

	// Gate clear with the run bit held keeps the timer enabled.
	property p_nogate_enable;
		@(posedge clk) disable iff (rst) (!gate_sel && run) [*2] |-> enabled_q;
	endproperty
	a_nogate_enable: assert property (p_nogate_enable) else $error("Enable lost with gate clear.");

	// Gate set and a low pin for four cycles blocks counting.
	property p_gate_block;
		@(posedge clk) disable iff (rst) (gate_sel && run && !gate_pin) [*4] |-> !enabled_q && !inc_q;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("Counted while gate pin low.");

	// Gate set and a high pin for four cycles lets the timer run.
	property p_gate_pass;
		@(posedge clk) disable iff (rst) (gate_sel && run && gate_pin) [*4] |-> enabled_q;
	endproperty
	a_gate_pass: assert property (p_gate_pass) else $error("Not enabled with gate pin high.");

	// A counter-mode increment traces back to a pin fall three cycles earlier.
	property p_count_cause;
		@(posedge clk) disable iff (rst) inc_q && $past(count_sel) |-> $past(count_pin, 4) && !$past(count_pin, 3);
	endproperty
	a_count_cause: assert property (p_count_cause) else $error("Count without pin fall.");

	// A falling edge produces a single pulse.
	property p_one_pulse;
		@(posedge clk) disable iff (rst) inc_q && $past(count_sel) |=> !inc_q;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("Double pulse for one edge.");

	// A timer-mode increment on the slow clock needs the slow tick.
	property p_timer_tick;
		@(posedge clk) disable iff (rst) inc_q && !$past(count_sel) && !$past(prescale_sel) |-> $past(tick_slow);
	endproperty
	a_timer_tick: assert property (p_timer_tick) else $error("Increment without timebase tick.");

	// With STOP_ON_MODE3 set, mode three never increments.
	property p_stop_hold;
		@(posedge clk) disable iff (rst) STOP_ON_MODE3 && mode == dtm_pkg::MODE_STOP |=> !inc_q;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("Increment in stopped mode.");

	// The decode is one-hot and follows the mode field.
	property p_mode_dec;
		@(posedge clk) disable iff (rst) ##1 $onehot(mode_dec_q) && mode_dec_q == (4'h1 << $past(mode));
	endproperty
	a_mode_dec: assert property (p_mode_dec) else $error("Mode decode mismatch.");

	// Main scenarios.
	c_count_edge: cover property (@(posedge clk) disable iff (rst) inc_q && $past(count_sel));
	c_gate_hold: cover property (@(posedge clk) disable iff (rst) gate_sel && run && !enabled_q);
	c_reload_mode: cover property (@(posedge clk) disable iff (rst) mode_dec_q[2] && inc_q);

endmodule : dtm_timer_ctl

// Top level: the timer mode register and both timer decoders.
module dtm_top (
	// Clock and reset.
	input  wire logic       CLK_SYS,
	input  wire logic       RST,
	// Special-function-register access.
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic       SFR_WR,
	input  wire logic       SFR_RD,
	input  wire logic [7:0] SFR_WDATA,
	output logic      [7:0] SFR_RDATA,
	// Run and prescale bits held elsewhere.
	input  wire logic       TIMER_ONE_RUN,
	input  wire logic       TIMER_ZERO_RUN,
	input  wire logic       TIMER_ONE_PRESCALE_SEL,
	input  wire logic       TIMER_ZERO_PRESCALE_SEL,
	// Board pins; gate is active at a high pin level.
	input  wire logic       EXT_GATE_IN_ONE_N,
	input  wire logic       EXT_GATE_IN_ZERO_N,
	input  wire logic       TIMER_ONE_COUNT_PIN,
	input  wire logic       TIMER_ZERO_COUNT_PIN,
	// Timer one results.
	output logic            TIMER_ONE_INC,
	output logic            TIMER_ONE_ENABLED,
	output logic      [3:0] TIMER_ONE_MODE_DEC,
	// Timer zero results.
	output logic            TIMER_ZERO_INC,
	output logic            TIMER_ZERO_ENABLED,
	output logic      [3:0] TIMER_ZERO_MODE_DEC
);

	logic [7:0] timer_mode_control_q; // The timer mode register.
	logic [3:0] presc_cnt_q;          // Slow timebase divider.
	logic       tick_slow_q;          // One pulse every divider period.
	logic       hit;                  // Access targets the mode register.

	assign hit = (SFR_ADDR == dtm_pkg::TIMER_MODE_CONTROL_ADDR);

	// Software writes the whole mode register in one access.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			timer_mode_control_q <= dtm_pkg::TIMER_MODE_CONTROL_RST;
		end else if (SFR_WR && hit) begin
			timer_mode_control_q <= SFR_WDATA;
		end
	end

	// Reads return the register; unmapped addresses read as zero.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			SFR_RDATA <= 8'h00;
		end else if (SFR_RD && hit) begin
			SFR_RDATA <= timer_mode_control_q;
		end else begin
			SFR_RDATA <= 8'h00;
		end
	end

	// Divider produces the slow internal clock as a one-cycle enable.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			presc_cnt_q <= dtm_pkg::PRESCALE_CNT_RST;
			tick_slow_q <= 1'b0;
		end else if (presc_cnt_q == dtm_pkg::PRESCALE_CNT_LAST) begin
			presc_cnt_q <= dtm_pkg::PRESCALE_CNT_RST;
			tick_slow_q <= 1'b1;
		end else begin
			presc_cnt_q <= presc_cnt_q + 4'h1;
			tick_slow_q <= 1'b0;
		end
	end

	// Timer one stops in mode three.
	dtm_timer_ctl #(
		.STOP_ON_MODE3 (1'b1)
	) u_timer_one (
		.clk          (CLK_SYS),
		.rst          (RST),
		.gate_sel     (timer_mode_control_q[dtm_pkg::TIMER_ONE_GATE_SEL_POS]),
		.count_sel    (timer_mode_control_q[dtm_pkg::TIMER_ONE_COUNT_SEL_POS]),
		.mode         (timer_mode_control_q[dtm_pkg::TIMER_ONE_MODE_FIELD_LSB +: 2]),
		.prescale_sel (TIMER_ONE_PRESCALE_SEL),
		.run          (TIMER_ONE_RUN),
		.gate_pin     (EXT_GATE_IN_ONE_N),
		.count_pin    (TIMER_ONE_COUNT_PIN),
		.tick_slow    (tick_slow_q),
		.inc_q        (TIMER_ONE_INC),
		.enabled_q    (TIMER_ONE_ENABLED),
		.mode_dec_q   (TIMER_ONE_MODE_DEC)
	);

	// Timer zero mode three is left to the counter datapath.
	dtm_timer_ctl #(
		.STOP_ON_MODE3 (1'b0)
	) u_timer_zero (
		.clk          (CLK_SYS),
		.rst          (RST),
		.gate_sel     (timer_mode_control_q[dtm_pkg::TIMER_ZERO_GATE_SEL_POS]),
		.count_sel    (timer_mode_control_q[dtm_pkg::TIMER_ZERO_COUNT_SEL_POS]),
		.mode         (timer_mode_control_q[dtm_pkg::TIMER_ZERO_MODE_FIELD_LSB +: 2]),
		.prescale_sel (TIMER_ZERO_PRESCALE_SEL),
		.run          (TIMER_ZERO_RUN),
		.gate_pin     (EXT_GATE_IN_ZERO_N),
		.count_pin    (TIMER_ZERO_COUNT_PIN),
		.tick_slow    (tick_slow_q),
		.inc_q        (TIMER_ZERO_INC),
		.enabled_q    (TIMER_ZERO_ENABLED),
		.mode_dec_q   (TIMER_ZERO_MODE_DEC)
	);

	// A write lands in the register on the next cycle.
	property p_reg_write;
		@(posedge CLK_SYS) disable iff (RST) SFR_WR && hit |=> timer_mode_control_q == $past(SFR_WDATA);
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("Mode register write lost.");

	// The slow tick repeats every twelve cycles.
	property p_tick_period;
		@(posedge CLK_SYS) disable iff (RST) tick_slow_q |=> !tick_slow_q [*8] ##1 !tick_slow_q [*3] ##1 tick_slow_q;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("Slow tick period wrong.");

	// Software reads back the register.
	c_readback: cover property (@(posedge CLK_SYS) disable iff (RST) $past(SFR_RD && hit) && SFR_RDATA != 8'h00);

endmodule : dtm_top

// File: dv/dtm_pin_model.sv
// Purpose: Board-side model of one external count pin.
// Assumes: The pin idles high and the block counts its falling edges.
// Notes:   Each pass drives two low and two high cycles, so every fall is seen once.
module dtm_pin_model (
	// Clock and request.
	input  wire logic clk,
	input  wire logic go,
	// Pin driven towards the block.
	output logic      count_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Phase of the current pulse; zero means idle.
	logic [1:0] ph_q = 2'h0;

	// The phase advances while asked and finishes any pulse already begun.
	always @(posedge clk) begin
		if (go || ph_q != 2'h0) begin
			ph_q <= ph_q + 2'h1;
		end
	end

	// Low in phases one and two, so the pin is high at least two cycles between falls.
	assign count_pin = !(ph_q == 2'h1 || ph_q == 2'h2);
endmodule : dtm_pin_model

// File: dv/dtm_top_bench.sv
// Purpose: Self-checking bench for the timer mode register and its decode.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Increment pulses are counted at every rising edge.
module dtm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// Clock, reset and register bus.
	logic       clk_sys = 1'h0;
	logic       rst     = 1'h1;
	logic       sfr_wr  = 1'h0;
	logic       sfr_rd  = 1'h0;
	logic [7:0] sfr_addr  = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	// Run, prescale, gate and pulse requests.
	logic       run1 = 1'h0;
	logic       run0 = 1'h0;
	logic       pre1 = 1'h0;
	logic       pre0 = 1'h0;
	logic       timer_one_gate_sel = 1'h0;
	logic       timer_zero_gate_sel = 1'h0;
	logic       go1 = 1'h0;
	logic       go0 = 1'h0;
	// Results.
	logic       pin1, pin0, inc1, inc0, en1, en0;
	logic [3:0] dec1, dec0;
	int         fail_count = 0;
	int         checks = 0;
	int         cyc = 0;
	int         n1 = 0;
	int         n0 = 0;
	int         a1, a0;
	logic [7:0] d;

	// Free-running 125 MHz clock.
	always #4 clk_sys = ~clk_sys;

	// Counts cycles and pulses, and cuts a hang short.
	always @(posedge clk_sys) begin
		cyc++;
		if (inc1 === 1'h1) n1++;
		if (inc0 === 1'h1) n0++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end

	dtm_top dut (.CLK_SYS(clk_sys), .RST(rst), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
		.SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .TIMER_ONE_RUN(run1), .TIMER_ZERO_RUN(run0),
		.TIMER_ONE_PRESCALE_SEL(pre1), .TIMER_ZERO_PRESCALE_SEL(pre0), .EXT_GATE_IN_ONE_N(timer_one_gate_sel),
		.EXT_GATE_IN_ZERO_N(timer_zero_gate_sel), .TIMER_ONE_COUNT_PIN(pin1), .TIMER_ZERO_COUNT_PIN(pin0),
		.TIMER_ONE_INC(inc1), .TIMER_ONE_ENABLED(en1), .TIMER_ONE_MODE_DEC(dec1),
		.TIMER_ZERO_INC(inc0), .TIMER_ZERO_ENABLED(en0), .TIMER_ZERO_MODE_DEC(dec0));
	dtm_pin_model pm1 (.clk(clk_sys), .go(go1), .count_pin(pin1));
	dtm_pin_model pm0 (.clk(clk_sys), .go(go0), .count_pin(pin0));

	// Compares a value and reports a mismatch at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Waits a number of falling edges.
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	// One register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'h1;
		@(negedge clk_sys);
		sfr_wr = 1'h0;
	endtask : wr

	// One register read; data stands the cycle after the read edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_rd = 1'h1;
		@(negedge clk_sys);
		sfr_rd = 1'h0;
		v = sfr_rdata;
	endtask : rd

	// Reset value, read-back and an unmapped address.
	task automatic t_reg();
		rd(8'h89, d);
		chk(d, 8'h00);
		wr(8'h89, 8'hA5);
		rd(8'h89, d);
		chk(d, 8'hA5);
		wr(8'h88, 8'hFF);
		rd(8'h89, d);
		chk(d, 8'hA5);
		rd(8'h88, d);
		chk(d, 8'h00);
		$display("register test done");
	endtask : t_reg

	// Gate control with gate pins low and high.
	task automatic t_gate();
		run1 = 1'h1;
		run0 = 1'h1;
		wr(8'h89, 8'h00);
		tick(5);
		chk({7'h00, en1}, 8'h01);
		chk({7'h00, en0}, 8'h01);
		wr(8'h89, 8'h88);
		tick(5);
		chk({7'h00, en1}, 8'h00);
		chk({7'h00, en0}, 8'h00);
		timer_one_gate_sel = 1'h1;
		timer_zero_gate_sel = 1'h1;
		tick(5);
		chk({7'h00, en1}, 8'h01);
		chk({7'h00, en0}, 8'h01);
		run1 = 1'h0;
		tick(3);
		chk({7'h00, en1}, 8'h00);
		run1 = 1'h1;
		$display("gate test done");
	endtask : t_gate

	// Every mode encoding on both fields.
	task automatic t_mode();
		for (int m = 0; m < 4; m++) begin
			wr(8'h89, {2'h0, 2'(m), 2'h0, 2'(m)});
			tick(3);
			chk({4'h0, dec1}, 8'(1 << m));
			chk({4'h0, dec0}, 8'(1 << m));
		end
		$display("mode test done");
	endtask : t_mode

	// Internal clock at full rate and divided by twelve, each timer taking both rates in turn.
	task automatic t_timer();
		wr(8'h89, 8'h00);
		pre1 = 1'h1;
		pre0 = 1'h0;
		tick(30);
		a1 = n1;
		a0 = n0;
		tick(48);
		chk(8'(n1 - a1), 8'h30);
		chk(8'(n0 - a0), 8'h04);
		pre1 = 1'h0;
		pre0 = 1'h1;
		tick(2);
		a1 = n1;
		a0 = n0;
		tick(48);
		chk(8'(n1 - a1), 8'h04);
		chk(8'(n0 - a0), 8'h30);
		$display("timer test done");
	endtask : t_timer

	// Pin falls counted once each; timer one stops in mode 11, timer zero still counts there.
	task automatic t_count();
		wr(8'h89, 8'h44);
		tick(5);
		a1 = n1;
		a0 = n0;
		go1 = 1'h1;
		go0 = 1'h1;
		tick(12);
		go1 = 1'h0;
		go0 = 1'h0;
		tick(10);
		chk(8'(n1 - a1), 8'h03);
		chk(8'(n0 - a0), 8'h03);
		wr(8'h89, 8'h77);
		tick(5);
		a1 = n1;
		a0 = n0;
		go1 = 1'h1;
		go0 = 1'h1;
		tick(8);
		go1 = 1'h0;
		go0 = 1'h0;
		tick(10);
		chk(8'(n1 - a1), 8'h00);
		chk(8'(n0 - a0), 8'h02);
		$display("count test done");
	endtask : t_count

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// Reset for four cycles, then every scenario in turn.
	initial begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h0;
		t_reg();
		t_gate();
		t_mode();
		t_timer();
		t_count();
		test_done();
	end
endmodule : dtm_top_bench
